// ---- disc_sector_sensing.sv ----
// sector sensing core: present sector per disc, sector and head
// storage, unit identity with look-ahead, read and write gating
// assumes tag commands, pulses and straps are synchronous to core_clk_in
//
// How it works
// - each sector is 1120 servo pulses, sectors count 0 to 47
// - removable and fixed discs keep separate pulse and sector counters
// - upper index pulse clears removable disc counters each revolution
// - lower index pulse clears fixed disc counters
// - fixed disc head selects fixed count, else removable count
// - sector with bits 4 and 5 both set is illegal, not stored
// - selected drive loads sector on address or alternate sector load
// - selected drive loads head from bits 8 and 9 on address load
// - attention set and request active drives bus line of unit number
// - four-jumper strap taken uninverted gives look-ahead added to present sector
// - identity only when sector plus look-ahead equals stored sector
// - read or write selected and sector equal raises sector match
// - sector match drops when pulse count reaches 1088
// - head switch between discs holds settle delay, suppressing match
// - illegal sector reported on bus bit 2 at next read, write, status
//
// The implementer's own choices: strobed register access and the address map.
`default_nettype none

module disc_sector_sensing
  import disc_sector_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        rstn_in,
  // servo pulse train and index pulses
  input  wire logic        servo_pulse_in,
  input  wire logic        upper_index_pulse_in,
  input  wire logic        lower_index_pulse_in,
  // tag bus commands and selection
  input  wire logic        drive_selected_in,
  input  wire logic        address_load_command_in,
  input  wire logic        alt_sector_load_command_in,
  input  wire logic        attention_request_command_in,
  input  wire logic        status_request_command_in,
  input  wire logic        read_command_in,
  input  wire logic        write_command_in,
  input  wire logic        read_select_in,
  input  wire logic        write_select_in,
  // control bus
  input  wire logic [15:0] control_bus_in,
  output logic      [15:0] control_bus_out,
  output logic      [15:0] control_bus_oe_out,
  // unit switch, straps and attention flip-flops
  input  wire logic [3:0]  unit_select_in,
  input  wire logic [3:0]  look_ahead_jumpers_n_in,
  input  wire logic [2:0]  attention_flags_in,
  // read and write gating
  output logic             sector_match_out,
  output logic             read_gate_out,
  output logic             write_gate_out,
  output logic             head_switch_settle_delay_out,
  output logic [1:0]       head_out,
  // register port
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_write_in,
  input  wire logic        reg_read_in,
  output logic      [31:0] reg_rdata_out,
  // interrupt
  output logic             irq_out
);

  // sum of present sector and look-ahead, wrapped at 48
  function automatic logic [5:0] add_wrap48(input logic [5:0] a, input logic [3:0] b);
    logic [6:0] sum;
    sum = {1'b0, a} + {3'h0, b};
    if (sum >= SECTORS_PER_REV)
      sum = sum - SECTORS_PER_REV;
    return sum[5:0];
  endfunction

  // a load is legal unless both upper sector bits are set
  function automatic logic sector_legal(input logic [15:0] bus);
    return !(bus[SECTOR_C4_BIT] && bus[SECTOR_C5_BIT]);
  endfunction

  sector_count_if removable_count ();
  sector_count_if fixed_count ();

  logic [5:0]  stored_sector;
  logic [1:0]  head;
  logic [3:0]  look_ahead;
  logic        strap_taken;
  logic        illegal_pending;
  logic [2:0]  status;
  logic [2:0]  mask;
  logic [1:0]  control;
  logic        settle_start;
  logic        settle_busy;
  logic        settle_done;
  logic        sector_load;
  logic        head_load;
  logic        fault_report;
  logic        fixed_selected;
  logic [5:0]  present_sector;
  logic [10:0] present_pulses;
  logic        sector_equal;
  logic        ident_hit;
  logic        next_match;
  logic        match_rise;
  logic [2:0]  events;
  logic [15:0] next_bus;
  logic [15:0] next_bus_oe;
  logic [31:0] next_rdata;

  // one counter set per disc, each with its own index
  sector_counter removable_counter (
    .core_clk_in    (core_clk_in),
    .rstn_in        (rstn_in),
    .servo_pulse_in (servo_pulse_in),
    .index_pulse_in (upper_index_pulse_in),
    .count_out      (removable_count)
  );

  sector_counter fixed_counter (
    .core_clk_in    (core_clk_in),
    .rstn_in        (rstn_in),
    .servo_pulse_in (servo_pulse_in),
    .index_pulse_in (lower_index_pulse_in),
    .count_out      (fixed_count)
  );

  settle_timer head_settle (
    .core_clk_in (core_clk_in),
    .rstn_in     (rstn_in),
    .start_in    (settle_start),
    .busy_out    (settle_busy),
    .done_out    (settle_done)
  );

  // heads 2 and 3 sit on the fixed disc
  assign fixed_selected = head[1];
  assign present_sector = fixed_selected ? fixed_count.sector : removable_count.sector;
  assign present_pulses = fixed_selected ? fixed_count.pulse_count : removable_count.pulse_count;

  // tag command decode for a selected drive
  assign sector_load  = drive_selected_in && (address_load_command_in || alt_sector_load_command_in);
  assign head_load    = drive_selected_in && address_load_command_in;
  assign fault_report = drive_selected_in && (read_command_in || write_command_in
                        || status_request_command_in);

  // settle only when the new head is on the other disc
  assign settle_start = head_load && (control_bus_in[HEAD_LO_BIT + 1] != head[1]);

  // strap caught once, on the first clock after reset release
  always_ff @(posedge core_clk_in)
  begin
    if (!rstn_in)
    begin
      strap_taken <= 1'b0;
      look_ahead  <= 4'h0;
    end
    else if (!strap_taken)
    begin
      strap_taken <= 1'b1;
      look_ahead  <= look_ahead_jumpers_n_in; // fitted jumper reads 0
    end
  end

  // sector address storage, illegal values leave the old one
  always_ff @(posedge core_clk_in)
  begin
    if (!rstn_in)
      stored_sector <= 6'h00;
    else if (sector_load && sector_legal(control_bus_in))
      stored_sector <= control_bus_in[SECTOR_HI_BIT:0];
  end

  // head storage
  always_ff @(posedge core_clk_in)
  begin
    if (!rstn_in)
      head <= 2'h0;
    else if (head_load)
      head <= control_bus_in[HEAD_LO_BIT + 1:HEAD_LO_BIT];
  end

  // illegal sector fault held until reported; a new illegal load wins
  always_ff @(posedge core_clk_in)
  begin
    if (!rstn_in)
      illegal_pending <= 1'b0;
    else if (sector_load && !sector_legal(control_bus_in))
      illegal_pending <= 1'b1;
    else if (fault_report)
      illegal_pending <= 1'b0;
  end

  // sector compare terms
  assign sector_equal = (present_sector == stored_sector);
  assign ident_hit    = (add_wrap48(present_sector, look_ahead) == stored_sector)
                        && (attention_flags_in != 3'h0)
                        && attention_request_command_in
                        && control[CTL_IDENT_EN];

  // match window ends at 1088 and is held off while settling
  assign next_match = (read_select_in || write_select_in)
                      && sector_equal
                      && (present_pulses < MATCH_END_COUNT)
                      && !settle_busy
                      && control[CTL_GATE_EN];

  assign match_rise = next_match && !sector_match_out;

  // sector match and the two gates
  always_ff @(posedge core_clk_in)
  begin
    if (!rstn_in)
    begin
      sector_match_out <= 1'b0;
      read_gate_out    <= 1'b0;
      write_gate_out   <= 1'b0;
    end
    else
    begin
      sector_match_out <= next_match;
      read_gate_out    <= next_match && read_select_in;
      write_gate_out   <= next_match && write_select_in;
    end
  end

  // settle delay and head out from flops
  always_ff @(posedge core_clk_in)
  begin
    if (!rstn_in)
    begin
      head_switch_settle_delay_out <= 1'b0;
      head_out                     <= 2'h0;
    end
    else
    begin
      head_switch_settle_delay_out <= settle_busy || settle_start;
      head_out                     <= head;
    end
  end

  // control bus drive: identity on the unit line, fault on bit 2
  always_comb
  begin
    next_bus    = 16'h0000;
    next_bus_oe = 16'h0000;
    if (ident_hit)
    begin
      next_bus[unit_select_in]    = 1'b1;
      next_bus_oe[unit_select_in] = 1'b1;
    end
    if (fault_report && illegal_pending)
    begin
      next_bus[FAULT_BIT]    = 1'b1;
      next_bus_oe[FAULT_BIT] = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rstn_in)
    begin
      control_bus_out    <= 16'h0000;
      control_bus_oe_out <= 16'h0000;
    end
    else
    begin
      control_bus_out    <= next_bus;
      control_bus_oe_out <= next_bus_oe;
    end
  end

  // events that feed the sticky status bits
  always_comb
  begin
    events             = 3'h0;
    events[EV_ILLEGAL] = sector_load && !sector_legal(control_bus_in);
    events[EV_MATCH]   = match_rise;
    events[EV_SETTLED] = settle_done;
  end

  // status: write one clears, a new event in the same cycle wins
  always_ff @(posedge core_clk_in)
  begin
    if (!rstn_in)
      status <= STATUS_RESET;
    else if (reg_write_in && reg_addr_in == STATUS_OFFSET)
      status <= (status & ~reg_wdata_in[2:0]) | events;
    else
      status <= status | events;
  end

  // mask and control registers
  always_ff @(posedge core_clk_in)
  begin
    if (!rstn_in)
    begin
      mask    <= MASK_RESET;
      control <= CONTROL_RESET;
    end
    else if (reg_write_in)
    begin
      if (reg_addr_in == MASK_OFFSET)
        mask <= reg_wdata_in[2:0];
      if (reg_addr_in == CONTROL_OFFSET)
        control <= reg_wdata_in[1:0];
    end
  end

  // read decode; unmapped offsets read zero
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    unique case (reg_addr_in)
      STATUS_OFFSET:  next_rdata = {29'h0, status};
      MASK_OFFSET:    next_rdata = {29'h0, mask};
      CONTROL_OFFSET: next_rdata = {30'h0, control};
      SECTORS_OFFSET: next_rdata = {8'h00, look_ahead, illegal_pending, settle_busy,
                                     head, 2'h0, stored_sector, 2'h0, present_sector};
      default:        next_rdata = 32'h0000_0000;
    endcase
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge core_clk_in)
  begin
    if (!rstn_in)
      reg_rdata_out <= 32'h0000_0000;
    else if (reg_read_in)
      reg_rdata_out <= next_rdata;
    else
      reg_rdata_out <= 32'h0000_0000;
  end

  // one level interrupt while any unmasked status bit is set
  always_ff @(posedge core_clk_in)
  begin
    if (!rstn_in)
      irq_out <= 1'b0;
    else
      irq_out <= |(status & mask);
  end

endmodule

`default_nettype wire

// ---- disc_sector_pkg.sv ----
// shared constants for the disc sector sensing block
// assumes a single 20 MHz clock and synchronous active-low reset
`default_nettype none

package disc_sector_pkg;

  // timing base
  localparam int CLK_FREQ_MHZ   = 20;
  localparam int SETTLE_TIME_US = 200;
  // least time: whole microseconds times MHz is already exact
  localparam int SETTLE_CYCLES  = SETTLE_TIME_US * CLK_FREQ_MHZ;

  // pulse and sector geometry
  localparam logic [10:0] PULSES_PER_SECTOR = 11'h460; // 1120
  localparam logic [10:0] MATCH_END_COUNT   = 11'h440; // 1088
  localparam logic [5:0]  LAST_SECTOR       = 6'h2f;   // 47
  localparam logic [6:0]  SECTORS_PER_REV   = 7'h30;   // 48

  // control bus field positions
  localparam int SECTOR_HI_BIT = 5;
  localparam int SECTOR_C4_BIT = 4;
  localparam int SECTOR_C5_BIT = 5;
  localparam int HEAD_LO_BIT   = 8;
  localparam int FAULT_BIT     = 2;

  // register offsets
  localparam logic [3:0] STATUS_OFFSET  = 4'h0;
  localparam logic [3:0] MASK_OFFSET    = 4'h4;
  localparam logic [3:0] CONTROL_OFFSET = 4'h8;
  localparam logic [3:0] SECTORS_OFFSET = 4'hc;

  // status and mask bit positions
  localparam int EV_ILLEGAL = 0;
  localparam int EV_MATCH   = 1;
  localparam int EV_SETTLED = 2;

  // control bit positions and reset values
  localparam int CTL_GATE_EN  = 0;
  localparam int CTL_IDENT_EN = 1;
  localparam logic [2:0] STATUS_RESET  = 3'h0;
  localparam logic [2:0] MASK_RESET    = 3'h0;
  localparam logic [1:0] CONTROL_RESET = 2'h3;

endpackage

`default_nettype wire

// ---- sector_count_if.sv ----
// carries one disc's present pulse count and sector number
// driven by a sector counter, read by the sensing core
`default_nettype none

interface sector_count_if;
  logic [10:0] pulse_count;
  logic [5:0]  sector;

  modport source (output pulse_count, output sector);
  modport sink   (input pulse_count, input sector);
endinterface

`default_nettype wire

// ---- sector_counter.sv ----
// divide-by-1120 pulse counter feeding a 0..47 sector counter
// assumes pulse and index inputs are one-cycle pulses on core_clk_in
`default_nettype none

module sector_counter
  import disc_sector_pkg::*;
(
  // clock and reset
  input  wire logic         core_clk_in,
  input  wire logic         rstn_in,
  // pulse train and index
  input  wire logic         servo_pulse_in,
  input  wire logic         index_pulse_in,
  // count out
  sector_count_if.source    count_out
);

  // index wins over a pulse in the same cycle
  always_ff @(posedge core_clk_in)
  begin
    if (!rstn_in || index_pulse_in)
    begin
      count_out.pulse_count <= 11'h000;
      count_out.sector      <= 6'h00;
    end
    else if (servo_pulse_in)
    begin
      if (count_out.pulse_count == PULSES_PER_SECTOR - 11'h001)
      begin
        count_out.pulse_count <= 11'h000;
        // a missed index must not run past sector 47
        if (count_out.sector == LAST_SECTOR)
          count_out.sector <= 6'h00;
        else
          count_out.sector <= count_out.sector + 6'h01;
      end
      else
        count_out.pulse_count <= count_out.pulse_count + 11'h001;
    end
  end

endmodule

`default_nettype wire

// ---- settle_timer.sv ----
// fixed-period head switch settle delay
// assumes start is a one-cycle pulse; a restart reloads the period
`default_nettype none

module settle_timer
  import disc_sector_pkg::*;
(
  // clock and reset
  input  wire logic core_clk_in,
  input  wire logic rstn_in,
  // control
  input  wire logic start_in,
  output logic      busy_out,
  output logic      done_out
);

  logic [12:0] remaining;

  // load on start, count down to zero
  always_ff @(posedge core_clk_in)
  begin
    if (!rstn_in)
    begin
      remaining <= 13'h0000;
      busy_out  <= 1'b0;
      done_out  <= 1'b0;
    end
    else if (start_in)
    begin
      remaining <= 13'(SETTLE_CYCLES - 1);
      busy_out  <= 1'b1;
      done_out  <= 1'b0;
    end
    else if (busy_out)
    begin
      remaining <= remaining - 13'h0001;
      busy_out  <= (remaining != 13'h0000);
      done_out  <= (remaining == 13'h0000);
    end
    else
      done_out <= 1'b0;
  end

endmodule

`default_nettype wire

// ---- disc_sector_sensing_props.sv ----
// checker for the disc sector sensing block, bound to its ports
// assumes one clock domain and the block's sync active-low reset
`default_nettype none

module disc_sector_sensing_props
  import disc_sector_pkg::*;
(
  // clock and reset
  input wire logic        core_clk_in,
  input wire logic        rstn_in,
  // watched inputs
  input wire logic        drive_selected_in,
  input wire logic        address_load_command_in,
  input wire logic        attention_request_command_in,
  input wire logic        status_request_command_in,
  input wire logic        read_command_in,
  input wire logic        write_command_in,
  input wire logic        read_select_in,
  input wire logic        write_select_in,
  input wire logic        reg_read_in,
  input wire logic [15:0] control_bus_in,
  input wire logic [3:0]  unit_select_in,
  input wire logic [2:0]  attention_flags_in,
  // watched outputs
  input wire logic [15:0] control_bus_out,
  input wire logic [15:0] control_bus_oe_out,
  input wire logic        sector_match_out,
  input wire logic        head_switch_settle_delay_out,
  input wire logic [1:0]  head_out,
  input wire logic [31:0] reg_rdata_out
);
  logic [10:0] run_len;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);

  // cycles of match already seen; a counter since the span is too long to unroll
  always_ff @(posedge core_clk_in)
  begin
    if (!rstn_in || !sector_match_out)
      run_len <= 11'h000;
    else
      run_len <= run_len + 11'h001;
  end

  AST_IDENT: assert property (
    control_bus_oe_out[unit_select_in] |-> $past(attention_request_command_in && (|attention_flags_in)))
    else $error("identity line driven without attention request");
  AST_UNIT: assert property (
    (control_bus_oe_out & ~(16'h1 << unit_select_in) & ~(16'h1 << FAULT_BIT)) == 16'h0)
    else $error("control bus line driven that is not ours");
  AST_FAULT: assert property (
    control_bus_oe_out[FAULT_BIT] |-> control_bus_out[FAULT_BIT]
      && $past(read_command_in || write_command_in || status_request_command_in))
    else $error("fault bit driven without a report command");
  AST_SELECT: assert property (
    sector_match_out |-> $past(read_select_in || write_select_in))
    else $error("sector match without read or write selected");
  AST_SUPPRESS: assert property (
    head_switch_settle_delay_out && $past(head_switch_settle_delay_out) |-> !sector_match_out)
    else $error("sector match during settle delay");
  AST_LENGTH: assert property (
    sector_match_out |-> run_len < 11'h440)
    else $error("sector match longer than its window");
  AST_SETTLE: assert property (
    $rose(head_switch_settle_delay_out) |-> head_switch_settle_delay_out [*8])
    else $error("settle delay too short");
  AST_HEAD: assert property (
    drive_selected_in && address_load_command_in |-> ##2 head_out == $past(control_bus_in[9:8], 2))
    else $error("head not loaded from the control bus");
  AST_RDATA: assert property (
    !$past(reg_read_in) |-> reg_rdata_out == 32'h0)
    else $error("read data outside its cycle");

  // main scenarios
  cover property ($rose(sector_match_out));
  cover property ($rose(control_bus_oe_out[FAULT_BIT]));
  cover property ($rose(head_switch_settle_delay_out));
  cover property ($rose(control_bus_oe_out[unit_select_in]));
endmodule

bind disc_sector_sensing disc_sector_sensing_props u_disc_sector_sensing_props (.*);

`default_nettype wire

// ---- disc_controller_model.sv ----
// behavioural disc controller issuing one-cycle tag commands
// assumes go_in is a one-cycle request from the bench
`default_nettype none

module disc_controller_model
(
  // clock
  input  wire logic        core_clk_in,
  // request from the bench
  input  wire logic        go_in,
  input  wire logic [2:0]  op_in,
  input  wire logic        sel_in,
  input  wire logic [15:0] data_in,
  // tag and control bus toward the drive
  output logic             drive_selected_out,
  output logic             address_load_out,
  output logic             alt_sector_load_out,
  output logic             status_request_out,
  output logic             read_command_out,
  output logic             write_command_out,
  output logic      [15:0] control_bus_out
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle at time zero
  initial
  begin
    {drive_selected_out, address_load_out, alt_sector_load_out} = 3'h0;
    {status_request_out, read_command_out, write_command_out} = 3'h0;
    control_bus_out = 16'h0;
  end

  // commands last one cycle; idle bus toggles so stale data never looks valid
  always @(posedge core_clk_in)
  begin
    drive_selected_out  <= go_in & sel_in;
    address_load_out    <= go_in & (op_in == 3'h0);
    alt_sector_load_out <= go_in & (op_in == 3'h1);
    status_request_out  <= go_in & (op_in == 3'h2);
    read_command_out    <= go_in & (op_in == 3'h3);
    write_command_out   <= go_in & (op_in == 3'h4);
    control_bus_out     <= go_in ? data_in : ~control_bus_out;
  end
endmodule

`default_nettype wire

// ---- test_disc_sector_sensing.sv ----
// self-checking bench for the disc sector sensing block
// assumes one servo pulse per clock and the controller model on the tag bus
`default_nettype none

module test_disc_sector_sensing;
  import disc_sector_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic        core_clk_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic        servo_pulse_in = 1'b0;
  logic        upper_index_pulse_in = 1'b0;
  logic        lower_index_pulse_in = 1'b0;
  logic        attention_request_command_in = 1'b0;
  logic        read_select_in = 1'b0;
  logic        write_select_in = 1'b0;
  logic [3:0]  unit_select_in = 4'h5;
  logic [3:0]  look_ahead_jumpers_n_in = 4'h3;
  logic [2:0]  attention_flags_in = 3'h0;
  logic [3:0]  reg_addr_in = 4'h0;
  logic [31:0] reg_wdata_in = 32'h0;
  logic        reg_write_in = 1'b0;
  logic        reg_read_in = 1'b0;
  logic        go = 1'b0;
  logic [2:0]  op = 3'h0;
  logic        sel = 1'b0;
  logic [15:0] cmd_data = 16'h0;
  wire logic   drive_selected_in, address_load_command_in, alt_sector_load_command_in;
  wire logic   status_request_command_in, read_command_in, write_command_in;
  wire logic [15:0] control_bus_in;
  logic [15:0] control_bus_out, control_bus_oe_out;
  logic        sector_match_out, read_gate_out, write_gate_out, head_switch_settle_delay_out, irq_out;
  logic [1:0]  head_out;
  logic [31:0] reg_rdata_out, rv;
  int          n_mismatch = 0, n_tests = 0, cyc = 0, ubase = 0, fbase = 0, cnt = 0, es = 0;

  disc_sector_sensing u_disc_sector_sensing (.*);

  disc_controller_model u_disc_controller_model (
    .core_clk_in(core_clk_in), .go_in(go), .op_in(op), .sel_in(sel), .data_in(cmd_data),
    .drive_selected_out(drive_selected_in), .address_load_out(address_load_command_in),
    .alt_sector_load_out(alt_sector_load_command_in), .status_request_out(status_request_command_in),
    .read_command_out(read_command_in), .write_command_out(write_command_in),
    .control_bus_out(control_bus_in));

  // clock and a cycle count used to place reads mid-sector
  always #25 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) cyc <= cyc + 1;

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_up(input int c, input int lim);
    if (c >= lim)
    begin
      n_mismatch++;
      complete_run();
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    @(posedge core_clk_in);
    reg_write_in <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    @(posedge core_clk_in);
    reg_read_in <= 1'b0;
    #1;
    d = reg_rdata_out;
  endtask

  // one tag command; returns in the cycle after the drive took it
  task automatic ctl(input logic [2:0] o, input logic s, input logic [15:0] d);
    @(posedge core_clk_in);
    go <= 1'b1;
    op <= o;
    sel <= s;
    cmd_data <= d;
    @(posedge core_clk_in);
    go <= 1'b0;
    @(posedge core_clk_in);
    #1;
  endtask

  // park mid-sector so a read never straddles a sector boundary
  task automatic mid(input int base);
    int i;
    for (i = 0; i < 1200 && ((cyc - base) % 1120) != 560; i++)
      @(posedge core_clk_in);
    give_up(i, 1200);
  endtask

  task automatic run_match(input logic w);
    cnt = 0;
    while (sector_match_out !== 1'b1 && cnt < 3000)
    begin
      @(posedge core_clk_in);
      #1;
      cnt++;
    end
    give_up(cnt, 3000);
    check((cyc - ubase) % 1120 < 8, 32'h1);
    cnt = 0;
    while (sector_match_out === 1'b1 && cnt < 2000)
    begin
      check({30'h0, write_gate_out, read_gate_out}, w ? 32'h2 : 32'h1);
      @(posedge core_clk_in);
      #1;
      cnt++;
    end
    give_up(cnt, 2000);
    check(cnt, 32'd1088);
  endtask

  initial
  begin
    repeat (5) @(posedge core_clk_in);
    rstn_in <= 1'b1;
    @(posedge core_clk_in);
    {upper_index_pulse_in, lower_index_pulse_in, servo_pulse_in} <= 3'h7;
    ubase = cyc;
    @(posedge core_clk_in);
    {upper_index_pulse_in, lower_index_pulse_in} <= 2'h0;
    reg_rd(STATUS_OFFSET, rv);
    check(rv, {29'h0, STATUS_RESET});
    reg_rd(MASK_OFFSET, rv);
    check(rv, {29'h0, MASK_RESET});
    reg_rd(CONTROL_OFFSET, rv);
    check(rv, {30'h0, CONTROL_RESET});
    reg_rd(4'h1, rv);
    check(rv, 32'h0);
    reg_rd(SECTORS_OFFSET, rv);
    check({28'h0, rv[23:20]}, 32'h3);
    $display("test registers done");
    // loads: plain, unselected, illegal, alternate
    ctl(3'h0, 1'b1, 16'h0002);
    check({30'h0, head_out}, 32'h0);
    ctl(3'h1, 1'b0, 16'h0007);
    ctl(3'h1, 1'b1, 16'h0031);
    reg_rd(SECTORS_OFFSET, rv);
    check({26'h0, rv[13:8]}, 32'h2);
    check({31'h0, rv[19]}, 32'h1);
    ctl(3'h1, 1'b1, 16'h0303);
    reg_rd(SECTORS_OFFSET, rv);
    check({26'h0, rv[13:8]}, 32'h3);
    check({30'h0, head_out}, 32'h0);
    // interrupt raised, then cleared by writing one
    reg_wr(MASK_OFFSET, 32'h1);
    repeat (2) @(posedge core_clk_in);
    #1;
    check({31'h0, irq_out}, 32'h1);
    reg_wr(STATUS_OFFSET, 32'h1);
    repeat (2) @(posedge core_clk_in);
    #1;
    check({31'h0, irq_out}, 32'h0);
    // fault reported once, then gone
    ctl(3'h2, 1'b1, 16'h0000);
    check({31'h0, control_bus_oe_out[FAULT_BIT] & control_bus_out[FAULT_BIT]}, 32'h1);
    ctl(3'h4, 1'b1, 16'h0000);
    check({31'h0, control_bus_oe_out[FAULT_BIT]}, 32'h0);
    $display("test loads done");
    mid(ubase);
    es = ((cyc - ubase) / 1120) % 48;
    reg_rd(SECTORS_OFFSET, rv);
    check({26'h0, rv[5:0]}, es);
    // read then write gating two sectors ahead
    for (int w = 0; w < 2; w++)
    begin
      mid(ubase);
      es = (((cyc - ubase) / 1120) + 2) % 48;
      ctl(3'h1, 1'b1, 16'(es));
      read_select_in <= (w == 0);
      write_select_in <= (w == 1);
      run_match(w[0]);
      {read_select_in, write_select_in} <= 2'h0;
    end
    reg_rd(STATUS_OFFSET, rv);
    check(rv, 32'h2);
    $display("test gating done");
    // identity three sectors early wraps round to sector 46
    ctl(3'h0, 1'b1, 16'h0001);
    attention_flags_in <= 3'h4;
    attention_request_command_in <= 1'b1;
    cnt = 0;
    while (control_bus_oe_out[unit_select_in] !== 1'b1 && cnt < 60000)
    begin
      @(posedge core_clk_in);
      #1;
      cnt++;
    end
    give_up(cnt, 60000);
    check({31'h0, control_bus_out[unit_select_in]}, 32'h1);
    check(((cyc - ubase) / 1120) % 48, 32'd46);
    attention_request_command_in <= 1'b0;
    attention_flags_in <= 3'h0;
    $display("test identity done");
    // fixed disc restarted mid-sector, then a switch to its head
    mid(ubase);
    lower_index_pulse_in <= 1'b1;
    fbase = cyc;
    @(posedge core_clk_in);
    lower_index_pulse_in <= 1'b0;
    ctl(3'h0, 1'b1, 16'h0200);
    cnt = 0;
    while (head_switch_settle_delay_out === 1'b1 && cnt < 5000)
    begin
      @(posedge core_clk_in);
      #1;
      cnt++;
    end
    give_up(cnt, 5000);
    check(cnt, SETTLE_CYCLES + 1);
    check({30'h0, head_out}, 32'h2);
    reg_rd(STATUS_OFFSET, rv);
    check(rv, 32'h6);
    mid(fbase);
    es = ((cyc - fbase) / 1120) % 48;
    reg_rd(SECTORS_OFFSET, rv);
    check({26'h0, rv[5:0]}, es);
    $display("test fixed disc done");
    complete_run();
  end
endmodule

`default_nettype wire
